// *** adc_link_pkg.sv ***
// Shared constants, types and helpers for the serial converter link
package adc_link_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int PTR_W = 3;
  localparam int RING_DEPTH = 8;
  localparam int FALL_W = 4;
  localparam int CNT_W = 8;

  // Transfer clock edge numbers within one frame
  localparam logic [FALL_W-1:0] SAMPLE_FALL = 4'h5;
  localparam logic [FALL_W-1:0] FRAME_CLOCKS = 4'h8;
  localparam logic [FALL_W-1:0] FALL_ZERO = 4'h0;
  localparam logic [FALL_W-1:0] FALL_ONE = 4'h1;

  // Conversion length in system clock cycles
  localparam int CONV_CYCLES = 36;

  // Internal test source
  localparam logic [ADDR_W-1:0] SELF_TEST_CHANNEL = 5'h13;
  localparam logic [DATA_W-1:0] SELF_TEST_CODE = 8'h80;
  localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;

  // Controller timing, in ns and derived cycles of ref_clk
  localparam int REF_PERIOD_NS = 5;
  localparam int IO_HALF_NS = 16;
  localparam int IO_HALF_CYC = (IO_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int HOST_SETUP_CYC = 8;
  localparam int CONV_WAIT_CYC = CONV_CYCLES + 8;

  typedef enum logic {
    ST_DESEL = 1'b0,
    ST_SEL = 1'b1
  } dev_state_type;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_SETUP = 3'h1,
    H_LOW = 3'h3,
    H_HIGH = 3'h2,
    H_WAIT = 3'h6
  } host_state_type;

  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int k = 1; k < PTR_W; k++) begin
      b = b ^ (g >> k);
    end
    return b;
  endfunction

endpackage

// *** adc_link_if.sv ***
// Serial link between controller and converter
`timescale 1ns/100ps
interface adc_link_if;
  logic cs_n;
  logic addr_in;
  logic io_clk;
  logic data_out;
  logic data_oe;
  logic data_line;

  // Released line is pulled high
  assign data_line = data_oe ? data_out : 1'b1;

  modport dev (
    input cs_n,
    input addr_in,
    input io_clk,
    output data_out,
    output data_oe
  );

  modport host (
    output cs_n,
    output addr_in,
    output io_clk,
    input data_line
  );
endinterface

// *** adc_host_ctrl.sv ***
// Controller end: runs one select and eight clock frame per request
`timescale 1ns/100ps
module adc_host_ctrl
  import adc_link_pkg::*;
#(
  parameter int HALF_CYC = IO_HALF_CYC,
  parameter int SETUP_CYC = HOST_SETUP_CYC,
  parameter int WAIT_CYC = CONV_WAIT_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  adc_link_if.host bus,
  input wire logic start,
  input wire logic [ADDR_W-1:0] chan,
  output logic busy,
  output logic [DATA_W-1:0] rx_data,
  output logic rx_valid
);

  typedef struct packed {
    host_state_type state;
    logic [CNT_W-1:0] cnt;
    logic [FALL_W-1:0] bits;
    logic [ADDR_W-1:0] addr_sr;
    logic [DATA_W-1:0] rx_sr;
    logic d_s1;
    logic d_s2;
    logic cs_n;
    logic addr_out;
    logic io_clk;
    logic busy;
    logic [DATA_W-1:0] rx_data;
    logic rx_valid;
  } host_reg_type;

  host_reg_type h_ff;
  host_reg_type nxt_h;

  always_comb begin
    nxt_h = h_ff;
    nxt_h.d_s1 = bus.data_line;
    nxt_h.d_s2 = h_ff.d_s1;
    nxt_h.rx_valid = 1'b0;
    if (h_ff.cnt != '0) begin
      nxt_h.cnt = h_ff.cnt - 1'b1;
    end
    case (h_ff.state)
      H_IDLE: begin
        if (h_ff.cnt != '0) begin
          // Link clock keeps running until the far end has left reset, ending low
          nxt_h.io_clk = ~h_ff.cnt[0];
        end else if (start) begin
          nxt_h.state = H_SETUP;
          nxt_h.cs_n = 1'b0;
          nxt_h.busy = 1'b1;
          nxt_h.addr_sr = chan;
          nxt_h.bits = FALL_ZERO;
          nxt_h.cnt = CNT_W'(SETUP_CYC);
        end
      end
      H_SETUP: begin
        if (h_ff.cnt == '0) begin
          nxt_h.state = H_LOW;
          nxt_h.addr_out = h_ff.addr_sr[ADDR_W-1];
          nxt_h.cnt = CNT_W'(HALF_CYC);
        end
      end
      H_LOW: begin
        if (h_ff.cnt == '0) begin
          nxt_h.state = H_HIGH;
          nxt_h.io_clk = 1'b1;
          nxt_h.cnt = CNT_W'(HALF_CYC);
        end
      end
      H_HIGH: begin
        if (h_ff.cnt == '0) begin
          nxt_h.io_clk = 1'b0;
          nxt_h.rx_sr = {h_ff.rx_sr[DATA_W-2:0], h_ff.d_s2};
          nxt_h.bits = h_ff.bits + FALL_ONE;
          nxt_h.addr_sr = {h_ff.addr_sr[ADDR_W-2:0], 1'b0};
          nxt_h.addr_out = h_ff.addr_sr[ADDR_W-2];
          nxt_h.cnt = CNT_W'(HALF_CYC);
          nxt_h.state = H_LOW;
          if (h_ff.bits == FRAME_CLOCKS - FALL_ONE) begin
            // Release select and keep it high across the conversion
            nxt_h.state = H_WAIT;
            nxt_h.cs_n = 1'b1;
            nxt_h.cnt = CNT_W'(WAIT_CYC);
            nxt_h.rx_data = {h_ff.rx_sr[DATA_W-2:0], h_ff.d_s2};
            nxt_h.rx_valid = 1'b1;
          end
        end
      end
      H_WAIT: begin
        if (h_ff.cnt == '0) begin
          nxt_h.state = H_IDLE;
          nxt_h.busy = 1'b0;
        end
      end
      default: begin
        nxt_h.state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      h_ff <= '0;
      h_ff.state <= H_IDLE;
      h_ff.cs_n <= 1'b1;
      h_ff.cnt <= CNT_W'(SETUP_CYC);
      // Transfer clock runs during reset so the far end can reset its link logic
      if (h_ff.cs_n) begin
        h_ff.io_clk <= ~h_ff.io_clk;
      end
    end else begin
      h_ff <= nxt_h;
    end
  end

  assign bus.cs_n = h_ff.cs_n;
  assign bus.addr_in = h_ff.addr_out;
  assign bus.io_clk = h_ff.io_clk;
  assign busy = h_ff.busy;
  assign rx_data = h_ff.rx_data;
  assign rx_valid = h_ff.rx_valid;

endmodule

// *** adc_dev_ctrl.sv ***
// Converter end: select recognition, serial shifting and conversion sequencing
`timescale 1ns/100ps
// Notes on behaviour
// - Select high: output released, clocks ignored
// - Select change recognized after synchroniser delay
// - Select recognized low drives result MSB
// - Address shifted in MSB first, five rises
// - First five falls shift bits two-six
// - Sampling starts after fifth fall
// - Falls six, seven shift last two bits
// - Eighth fall holds, starts 36-cycle conversion
// - Controller waits 44 cycles after frame
// - Select may stay low across conversions
// - Controller keeps select high until done
// - Select recognized low mid-conversion aborts it
// - New frame restarts conversion, old result out
// - Address 10011 converts internal test code
// - Sampling lasts three transfer clock cycles
// - Transfer clock sampled on system clock, so it must run slower
module adc_dev_ctrl
  import adc_link_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  adc_link_if.dev bus,
  input wire logic [DATA_W-1:0] sample_code,
  output logic [ADDR_W-1:0] chan_sel,
  output logic sampling,
  output logic converting,
  output logic [DATA_W-1:0] result,
  output logic result_valid
);

  localparam int CONV_W = $clog2(CONV_LEN);
  localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_LEN - 1);

  // Link clock domain: address bits land in a ring indexed by a binary pointer, with a gray copy for the crossing
  typedef struct packed {
    logic rs1;
    logic rs2;
    logic [PTR_W-1:0] wr_bin;
    logic [PTR_W-1:0] wr_gray;
    logic [RING_DEPTH-1:0] mem;
  } dev_io_type;

  // System clock domain
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_rec;
    logic io_s1;
    logic io_s2;
    logic io_prev;
    logic [PTR_W-1:0] ptr_s1;
    logic [PTR_W-1:0] ptr_s2;
    logic [PTR_W-1:0] base;
    dev_state_type state;
    logic [FALL_W-1:0] falls;
    logic [CONV_W-1:0] conv_cnt;
    logic converting;
    logic sampling;
    logic [ADDR_W-1:0] chan;
    logic [DATA_W-1:0] shift;
    logic [DATA_W-1:0] out_reg;
    logic [DATA_W-1:0] held;
    logic [DATA_W-1:0] result;
    logic result_valid;
    logic dout;
    logic doe;
  } dev_ref_type;

  dev_io_type io_ff;
  dev_io_type nxt_io;
  dev_ref_type r_ff;
  dev_ref_type nxt_r;

  // Link side: every rising transfer clock edge out of reset stores the address pin; during reset it clears the ring
  always_comb begin
    nxt_io = io_ff;
    nxt_io.rs1 = reset_n;
    nxt_io.rs2 = io_ff.rs1;
    if (!io_ff.rs2) begin
      nxt_io.wr_bin = '0;
      nxt_io.wr_gray = '0;
      nxt_io.mem = '0;
    end else begin
      nxt_io.mem[io_ff.wr_bin] = bus.addr_in;
      nxt_io.wr_bin = io_ff.wr_bin + 1'b1;
      nxt_io.wr_gray = bin2gray(nxt_io.wr_bin);
    end
  end

  always_ff @(posedge bus.io_clk) begin
    io_ff <= nxt_io;
  end

  // System side
  logic sel_fall;
  logic sel_rise;
  logic io_fall;
  logic [ADDR_W-1:0] addr_word;
  logic [PTR_W-1:0] rd_idx;

  always_comb begin
    addr_word = '0;
    rd_idx = '0;
    // Entries for this frame are stable once the pointer has passed them
    for (int k = 0; k < ADDR_W; k++) begin
      rd_idx = r_ff.base + PTR_W'(k);
      addr_word[ADDR_W-1-k] = io_ff.mem[rd_idx];
    end
  end

  assign sel_fall = r_ff.cs_rec & ~r_ff.cs_s2;
  assign sel_rise = ~r_ff.cs_rec & r_ff.cs_s2;
  assign io_fall = r_ff.io_prev & ~r_ff.io_s2;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.cs_s1 = bus.cs_n;
    nxt_r.cs_s2 = r_ff.cs_s1;
    nxt_r.cs_rec = r_ff.cs_s2;
    nxt_r.io_s1 = bus.io_clk;
    nxt_r.io_s2 = r_ff.io_s1;
    nxt_r.io_prev = r_ff.io_s2;
    nxt_r.ptr_s1 = io_ff.wr_gray;
    nxt_r.ptr_s2 = r_ff.ptr_s1;
    nxt_r.result_valid = 1'b0;

    // Conversion counter runs on the system clock only
    if (r_ff.converting && !sel_fall) begin
      if (r_ff.conv_cnt == CONV_LAST) begin
        nxt_r.converting = 1'b0;
        nxt_r.out_reg = r_ff.held;
        nxt_r.result = r_ff.held;
        nxt_r.result_valid = 1'b1;
        if (r_ff.state == ST_SEL && r_ff.falls == FALL_ZERO) begin
          nxt_r.shift = r_ff.held;
          nxt_r.dout = r_ff.held[DATA_W-1];
        end
      end else begin
        nxt_r.conv_cnt = r_ff.conv_cnt + 1'b1;
      end
    end

    case (r_ff.state)
      ST_DESEL: begin
        nxt_r.doe = 1'b0;
        if (sel_fall) begin
          nxt_r.state = ST_SEL;
          nxt_r.doe = 1'b1;
          nxt_r.shift = r_ff.out_reg;
          nxt_r.dout = r_ff.out_reg[DATA_W-1];
          nxt_r.falls = FALL_ZERO;
          nxt_r.base = gray2bin(r_ff.ptr_s2);
          nxt_r.converting = 1'b0;
        end
      end
      ST_SEL: begin
        // A fall seen together with the select release still counts: it came first
        if (io_fall) begin
          nxt_r.falls = r_ff.falls + FALL_ONE;
          nxt_r.shift = {r_ff.shift[DATA_W-2:0], 1'b0};
          nxt_r.dout = r_ff.shift[DATA_W-2];
          if (r_ff.falls == SAMPLE_FALL - FALL_ONE) begin
            nxt_r.chan = addr_word;
            nxt_r.sampling = 1'b1;
          end
          if (r_ff.falls == FRAME_CLOCKS - FALL_ONE) begin
            // Hold ends the three-cycle acquisition and starts a fresh conversion
            nxt_r.sampling = 1'b0;
            nxt_r.falls = FALL_ZERO;
            nxt_r.converting = 1'b1;
            nxt_r.conv_cnt = '0;
            nxt_r.held = (r_ff.chan == SELF_TEST_CHANNEL) ? SELF_TEST_CODE : sample_code;
            nxt_r.base = r_ff.base + PTR_W'(FRAME_CLOCKS);
            // Select kept low: next frame shows the last finished result
            nxt_r.shift = r_ff.out_reg;
            nxt_r.dout = r_ff.out_reg[DATA_W-1];
          end
        end
        if (sel_rise) begin
          nxt_r.state = ST_DESEL;
          nxt_r.doe = 1'b0;
          nxt_r.sampling = 1'b0;
        end
      end
      default: begin
        nxt_r.state = ST_DESEL;
        nxt_r.doe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r_ff <= '0;
      r_ff.cs_s1 <= 1'b1;
      r_ff.cs_s2 <= 1'b1;
      r_ff.cs_rec <= 1'b1;
      r_ff.state <= ST_DESEL;
      r_ff.out_reg <= RESULT_RST;
      r_ff.result <= RESULT_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign bus.data_out = r_ff.dout;
  assign bus.data_oe = r_ff.doe;
  assign chan_sel = r_ff.chan;
  assign sampling = r_ff.sampling;
  assign converting = r_ff.converting;
  assign result = r_ff.result;
  assign result_valid = r_ff.result_valid;

endmodule

// *** adc_link_checker.sv ***
// Link checker: select recognition, output release and framing
`timescale 1ns/100ps
module adc_link_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic addr_in,
  input wire logic io_clk,
  input wire logic data_out,
  input wire logic data_oe
);
  logic [3:0] rise_ff;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Transfer clock rises within one select
  always_ff @(posedge ref_clk) begin
    if (!reset_n || cs_n) begin
      rise_ff <= 4'h0;
    end else if ($rose(io_clk)) begin
      rise_ff <= rise_ff + 4'h1;
    end
  end
  sequence sel_low_s;
    !cs_n [*6];
  endsequence
  sequence sel_high_s;
    cs_n [*5];
  endsequence
  oe_on_a: assert property (sel_low_s |-> data_oe)
    else $error("data output not driven while selected");
  oe_off_a: assert property (sel_high_s |-> !data_oe)
    else $error("data output driven while deselected");
  oe_delay_a: assert property ($fell(cs_n) |-> !data_oe [*3])
    else $error("select recognized too early");
  msb_hold_a: assert property ($rose(data_oe) |=> $stable(data_out) [*6])
    else $error("first bit changed without transfer clock");
  data_edge_a: assert property (data_oe && $past(data_oe) && $changed(data_out) |-> !io_clk)
    else $error("data changed while transfer clock high");
  addr_edge_a: assert property ($changed(addr_in) |-> !io_clk)
    else $error("address changed while transfer clock high");
  frame_end_a: assert property ($fell(io_clk) && rise_ff == 4'h8 |-> cs_n)
    else $error("select still low after eighth clock");
  sel_setup_a: assert property ($fell(cs_n) |-> !$rose(io_clk) [*4])
    else $error("transfer clock before select setup");
endmodule

// *** test_serial_adc_control_sequencer.sv ***
// Bench: controller and converter ends joined over the link
`timescale 1ns/100ps
module test_serial_adc_control_sequencer;
  import adc_link_pkg::*;
  localparam int HALF = 6;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic [ADDR_W-1:0] chan = 5'h00;
  logic [DATA_W-1:0] sample_code = 8'h00;
  logic busy, rx_valid, sampling, converting, result_valid;
  logic [DATA_W-1:0] rx_data, result, last_res;
  logic [ADDR_W-1:0] chan_sel;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int samp_n = 0;
  adc_link_if bus();
  adc_host_ctrl #(.HALF_CYC(HALF), .SETUP_CYC(8), .WAIT_CYC(4)) u_adc_host_ctrl (.ref_clk(ref_clk),
    .reset_n(reset_n), .bus(bus), .start(start), .chan(chan), .busy(busy), .rx_data(rx_data), .rx_valid(rx_valid));
  adc_dev_ctrl #(.CONV_LEN(CONV_CYCLES)) u_adc_dev_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus),
    .sample_code(sample_code), .chan_sel(chan_sel), .sampling(sampling), .converting(converting),
    .result(result), .result_valid(result_valid));
  adc_link_checker u_adc_link_checker (.ref_clk(ref_clk), .reset_n(reset_n), .cs_n(bus.cs_n),
    .addr_in(bus.addr_in), .io_clk(bus.io_clk), .data_out(bus.data_out), .data_oe(bus.data_oe));
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %b", $time, what, got);
    end
  endtask
  // One select and eight clock transfer, reading the previous result
  task automatic frame(input logic [ADDR_W-1:0] ch, input logic [DATA_W-1:0] code);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chan = ch;
    sample_code = code;
    start = 1'b1;
    samp_n = 0;
    @(negedge ref_clk);
    start = 1'b0;
    while (rx_valid !== 1'b1 && n < 600) begin
      samp_n += int'(sampling === 1'b1);
      @(negedge ref_clk);
      n++;
    end
    check_byte(rx_data, last_res, "readout");
    check_byte({3'h0, chan_sel}, {3'h0, ch}, "held channel");
  endtask
  // Waits for the conversion and checks its length and outcome
  task automatic conv(input logic [ADDR_W-1:0] ch, input logic [DATA_W-1:0] code);
    int n;
    n = 0;
    while (converting !== 1'b1 && n < 60) begin
      samp_n += int'(sampling === 1'b1);
      @(negedge ref_clk);
      n++;
    end
    check_byte(8'(samp_n), 8'(3 * 2 * (HALF + 1)), "sample window");
    n = 0;
    while (result_valid !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    check_byte(8'(n), 8'(CONV_CYCLES), "conversion length");
    last_res = (ch === SELF_TEST_CHANNEL) ? SELF_TEST_CODE : code;
    check_bit(ch !== SELF_TEST_CHANNEL || (result >= 8'h7D && result <= 8'h83), 1'b1, "test code");
    check_byte(result, last_res, "result");
    check_bit(bus.data_line, 1'b1, "released line");
  endtask
  initial begin
    logic [DATA_W-1:0] code;
    logic [ADDR_W-1:0] ch;
    code = 8'($urandom(32'h03714B6D));
    last_res = RESULT_RST;
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (12) @(negedge ref_clk);
    for (int i = 0; i < 14; i++) begin
      ch = (i == 1) ? SELF_TEST_CHANNEL : (i == 2) ? 5'h00 : (i == 5) ? 5'h12 : 5'($urandom_range(0, 19));
      code = 8'($urandom());
      frame(ch, code);
      if (i % 4 == 3) begin
        ch = 5'($urandom_range(0, 18));
        code = 8'($urandom());
        frame(ch, code);
        check_byte(result, last_res, "kept after abort");
      end
      conv(ch, code);
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule
